/* File: core/irq_prio_pkg.sv */
// Purpose: constants for the motor interrupt priority registers
// Assumes: classic wishbone, 32-bit data, word-aligned registers
// Notes:   offsets are byte addresses
package irq_prio_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ENC_PWM_OFFSET   = 8'h00; // encoder_pwm_priority
  localparam logic [7:0]  PWM_FAULT_OFFSET = 8'h04; // pwm_fault_priority
  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int          LEVEL_W          = 3;     // width of one level field
  localparam int          ENC_LSB          = 8;     // encoder_irq_level 10:8
  localparam int          PWM1_LSB         = 4;     // pwm_gen1_irq_level 6:4
  localparam int          FAULT_LSB        = 12;    // pwm_gen1_fault_irq_level 14:12
  localparam logic [2:0]  LEVEL_RESET      = 3'h4;  // level 4 after reset
  localparam logic [2:0]  LEVEL_OFF        = 3'h0;  // source disabled
  localparam logic [15:0] ENC_PWM_RESET    = 16'h0440;
  localparam logic [15:0] PWM_FAULT_RESET  = 16'h4000;
endpackage

/* File: core/motor_irq_priority_regs.sv */
// Purpose: two software priority registers feeding interrupt arbitration
// Assumes: classic wishbone slave, one clock, async active-low reset
// Notes:   ack one cycle after request; unmapped reads return zero
//
// Function
// R1: encoder level at bits 10:8, register one
// R2: pwm generator level at bits 6:4
// R3: pwm fault level at bits 14:12, register two
// R4: field value is the priority level directly
// R5: level zero disables the source
// R6: unused bits ignore writes, read zero
// R7: all fields reset to level four
`timescale 1ns/10ps
module motor_irq_priority_regs (
  input  wire logic        core_clk_i,          // system clock, 100 MHz
  input  wire logic        rst_n_i,             // async reset, active low
  input  wire logic        wb_cyc_i,            // bus cycle
  input  wire logic        wb_stb_i,            // strobe
  input  wire logic        wb_we_i,             // write enable
  input  wire logic [7:0]  wb_adr_i,            // byte address
  input  wire logic [3:0]  wb_sel_i,            // byte lanes
  input  wire logic [31:0] wb_dat_i,            // write data
  output logic      [31:0] wb_dat_o,            // read data
  output logic             wb_ack_o,            // acknowledge
  output logic      [2:0]  encoder_irq_level_o, // level to arbiter
  output logic      [2:0]  pwm_gen1_irq_level_o,
  output logic      [2:0]  pwm_gen1_fault_irq_level_o,
  output logic             encoder_irq_en_o,    // source enabled
  output logic             pwm_gen1_irq_en_o,
  output logic             pwm_gen1_fault_irq_en_o
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // the three level fields; every other register bit is tied to zero
  logic [2:0] enc_lvl;   // encoder level field, bits 10:8 of register one
  logic [2:0] pwm_lvl;   // generator level field, bits 6:4 of register one
  logic [2:0] flt_lvl;   // fault level field, bits 14:12 of register two

  // a request counts as new only while no ack is out; a master that keeps
  // strobe up past the ack is served every other cycle, never twice in a row
  wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr       = req & wb_we_i;        // write half of a new request

  // full eight-bit compare, so no other offset aliases onto a register
  wire        hit_a    = wb_adr_i == irq_prio_pkg::ENC_PWM_OFFSET;   // encoder_pwm_priority
  wire        hit_b    = wb_adr_i == irq_prio_pkg::PWM_FAULT_OFFSET; // pwm_fault_priority

  // byte lanes: a field is written only when the lane holding it is set,
  // so software can update the encoder level without touching the generator level
  wire        lane_hi  = wb_sel_i[1];          // lane for bits 15:8
  wire        lane_lo  = wb_sel_i[0];          // lane for bits 7:0

  // per-field write strobes
  wire        wr_enc   = wr & hit_a & lane_hi; // R1
  wire        wr_pwm   = wr & hit_a & lane_lo; // R2
  wire        wr_flt   = wr & hit_b & lane_hi; // R3

  // new field values, cut straight out of the data bus; bits outside the
  // three slices are never stored, which is what keeps them at zero
  wire [2:0]  enc_din  = wb_dat_i[irq_prio_pkg::ENC_LSB +: irq_prio_pkg::LEVEL_W];   // R4
  wire [2:0]  pwm_din  = wb_dat_i[irq_prio_pkg::PWM1_LSB +: irq_prio_pkg::LEVEL_W];  // R4
  wire [2:0]  flt_din  = wb_dat_i[irq_prio_pkg::FAULT_LSB +: irq_prio_pkg::LEVEL_W]; // R4

  // read images: levels in their slots, unused positions tied low
  wire [15:0] reg_a    = {5'h00, enc_lvl, 1'h0, pwm_lvl, 4'h0}; // R6
  wire [15:0] reg_b    = {1'h0, flt_lvl, 12'h000};              // R6

  // registers sit in the low half of the word; the high half and any
  // unmapped offset read as zero
  wire [31:0] next_rd  = hit_a ? {16'h0000, reg_a} :
                         hit_b ? {16'h0000, reg_b} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // level fields
  // ----------------------------------------------------------------
  // encoder level; reset puts the source at level 4
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enc_lvl <= irq_prio_pkg::LEVEL_RESET; // R7
    end else if (wr_enc) begin
      enc_lvl <= enc_din;                   // R1
    end
  end

  // generator level; shares register one with the encoder, own lane
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_lvl <= irq_prio_pkg::LEVEL_RESET; // R7
    end else if (wr_pwm) begin
      pwm_lvl <= pwm_din;                   // R2
    end
  end

  // fault level; the only field of register two
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flt_lvl <= irq_prio_pkg::LEVEL_RESET; // R7
    end else if (wr_flt) begin
      flt_lvl <= flt_din;                   // R3
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // ack follows the taking edge by one cycle and stands one cycle; read
  // data is captured with the request and is zero outside the ack cycle,
  // so a bus that ors slave outputs together sees nothing from us at rest
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;                           // every request is answered
      wb_dat_o <= req ? next_rd : 32'h0000_0000; // R6
    end
  end

  // ----------------------------------------------------------------
  // arbiter outputs
  // ----------------------------------------------------------------
  // a zero level takes the source out of arbitration altogether
  wire        enc_on   = enc_lvl != irq_prio_pkg::LEVEL_OFF; // R5
  wire        pwm_on   = pwm_lvl != irq_prio_pkg::LEVEL_OFF; // R5
  wire        flt_on   = flt_lvl != irq_prio_pkg::LEVEL_OFF; // R5

  // levels are registered so the arbiter sees clean flop outputs; the
  // price is one cycle of lag after a write, harmless for a priority
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      encoder_irq_level_o        <= irq_prio_pkg::LEVEL_RESET;
      pwm_gen1_irq_level_o       <= irq_prio_pkg::LEVEL_RESET;
      pwm_gen1_fault_irq_level_o <= irq_prio_pkg::LEVEL_RESET;
    end else begin
      encoder_irq_level_o        <= enc_lvl; // R4
      pwm_gen1_irq_level_o       <= pwm_lvl; // R4
      pwm_gen1_fault_irq_level_o <= flt_lvl; // R4
    end
  end

  // enables move in the same cycle as their levels, so the pair never
  // disagrees at the arbiter; reset level 4 means every source starts on
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      encoder_irq_en_o           <= 1'h1;
      pwm_gen1_irq_en_o          <= 1'h1;
      pwm_gen1_fault_irq_en_o    <= 1'h1;
    end else begin
      encoder_irq_en_o           <= enc_on; // R5
      pwm_gen1_irq_en_o          <= pwm_on; // R5
      pwm_gen1_fault_irq_en_o    <= flt_on; // R5
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // a selected write lands in its field at the taking edge
  a_enc_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R1
    wr_enc |=> enc_lvl == $past(wb_dat_i[10:8])) else $error("encoder level not written");
  a_pwm_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R2
    wr_pwm |=> pwm_lvl == $past(wb_dat_i[6:4])) else $error("pwm level not written");
  a_fault_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R3
    wr_flt |=> flt_lvl == $past(wb_dat_i[14:12])) else $error("fault level not written");

  // a write to register one with the upper lane off leaves the encoder alone
  a_lane_guard: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R1
    wr && hit_a && !wb_sel_i[1] |=> $stable(enc_lvl))
    else $error("encoder level changed without its lane");

  // the encoder and fault outputs to the arbiter carry the written code two edges after the write
  a_level_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    wr_enc ##1 1'h1 |=> encoder_irq_level_o == $past(wb_dat_i[10:8], 2))
    else $error("level output wrong");
  a_fault_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    wr_flt ##1 1'h1 |=> pwm_gen1_fault_irq_level_o == $past(wb_dat_i[14:12], 2))
    else $error("fault level output wrong");

  // each enable is low exactly when the field held code zero a cycle ago
  a_zero_disables: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
    {encoder_irq_en_o, pwm_gen1_irq_en_o, pwm_gen1_fault_irq_en_o} ==
    {$past(enc_lvl) != 3'h0, $past(pwm_lvl) != 3'h0, $past(flt_lvl) != 3'h0})
    else $error("enable does not match level");

  // unused positions read zero, each register with its own mask
  a_unused_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    wb_ack_o && $past(hit_a) |-> (wb_dat_o & 32'hffff_f88f) == 32'h0000_0000)
    else $error("unused bits of register one read nonzero");
  a_unused_fault: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    wb_ack_o && $past(hit_b) |-> (wb_dat_o & 32'hffff_8fff) == 32'h0000_0000)
    else $error("unused bits of register two read nonzero");
  a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    wb_ack_o && !$past(hit_a) && !$past(hit_b) |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped offset read nonzero");
  a_read_back: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    req && !wb_we_i && hit_b |=> wb_dat_o == {16'h0000, $past(reg_b)})
    else $error("read data wrong");

  // ack is a single-cycle pulse
  a_ack_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

  // after reset both registers and all three level outputs to the arbiter sit at level 4
  a_reset_value: assert property (@(posedge core_clk_i) // R7
    $rose(rst_n_i) |-> reg_a == irq_prio_pkg::ENC_PWM_RESET
                    && reg_b == irq_prio_pkg::PWM_FAULT_RESET)
    else $error("reset value wrong");
  a_reset_outputs: assert property (@(posedge core_clk_i) // R7
    $rose(rst_n_i) |-> {encoder_irq_level_o, pwm_gen1_irq_level_o,
                        pwm_gen1_fault_irq_level_o} == {3{irq_prio_pkg::LEVEL_RESET}})
    else $error("arbiter outputs not at reset level");
endmodule

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the motor interrupt priority registers
// Assumes: classic wishbone, ack one cycle after the request edge
// Notes:   the driver queues expected reads, the monitor checks them at ack
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;                      // byte address
  logic [3:0]  sel = 4'h0;                       // byte lanes
  logic [31:0] dat = 32'h0, rdat;                // write and read data
  logic        ack, en_e, en_p, en_f;            // ack and source enables
  logic [2:0]  lv_e, lv_p, lv_f;                 // levels to the arbiter
  logic [15:0] e_rd, exp_q[$];                   // expected read values
  int          mismatches = 0, check_count = 0;
  always #5 core_clk_i = ~core_clk_i;
  motor_irq_priority_regs dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .encoder_irq_level_o(lv_e), .pwm_gen1_irq_level_o(lv_p),
    .pwm_gen1_fault_irq_level_o(lv_f), .encoder_irq_en_o(en_e), .pwm_gen1_irq_en_o(en_p),
    .pwm_gen1_fault_irq_en_o(en_f));
  // monitor: read data is only valid in the ack cycle, so check it there
  always @(posedge core_clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      e_rd = exp_q.pop_front();
      `CHK(rdat, {16'h0000, e_rd})
    end
  end
  task automatic test_done;
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one classic cycle: hold everything until ack, then idle one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= v; sel <= s;
    do begin @(posedge core_clk_i); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin mismatches++; test_done(); end
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, $urandom, 4'hf);
  endtask
  // levels lag the field by a cycle; wb already waited past that edge
  task automatic lv(input logic [2:0] e, input logic [2:0] p, input logic [2:0] x);
    `CHK({lv_e, lv_p, lv_f}, {e, p, x})
    `CHK({en_e, en_p, en_f}, {e != 3'h0, p != 3'h0, x != 3'h0})
  endtask
  initial begin
    logic [15:0] e0, e4, mk;
    logic [31:0] d;
    logic [3:0]  s;
    e0 = irq_prio_pkg::ENC_PWM_RESET;   // shadow of register one
    e4 = irq_prio_pkg::PWM_FAULT_RESET; // shadow of register two
    void'($urandom(32'hc8747c33));
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    lv(3'h4, 3'h4, 3'h4);
    rd(8'h00, 16'h0440);
    rd(8'h04, 16'h4000);
    // all zeros, all ones, then random data with random byte lanes
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
      s = (i < 2) ? 4'hf : 4'($urandom);
      mk = {{8{s[1]}}, {8{s[0]}}};
      e0 = ((e0 & ~mk) | (d[15:0] & mk)) & 16'h0770;
      e4 = ((e4 & ~mk) | (d[31:16] & mk)) & 16'h7000;
      wb(1'b1, 8'h00, d, s);
      wb(1'b1, 8'h04, {d[15:0], d[31:16]}, s);
      rd(8'h00, e0);
      rd(8'h04, e4);
      lv(e0[10:8], e0[6:4], e4[14:12]);
    end
    // unmapped write must not alias onto a real register
    wb(1'b1, 8'h08, 32'hffffffff, 4'hf);
    rd(8'h08, 16'h0000);
    rd(8'h00, e0);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    lv(3'h4, 3'h4, 3'h4);
    rd(8'h04, 16'h4000);
    rd(8'h00, 16'h0440);
    test_done();
  end
endmodule
